// >>> rtl/whp_map.svh
// register offsets, field positions, reset values and timing figures
`ifndef WHP_MAP_SVH
`define WHP_MAP_SVH

// ----------------------------------------------------------------
// clock and timing figures
// ----------------------------------------------------------------
`define WHP_CLK_HZ 20000000
`define WHP_SPI_MAX_HZ 20000000
`define WHP_HIB_MIN_MS 10
`define WHP_WAKE_MS 50
`define WHP_RECAL_MS 200
`define WHP_HW_WAKE_MS 25
`define WHP_INIT_MS 1350
`define WHP_BAUD_DEF 115200
`define WHP_BAUD_MAX 3000000
`define WHP_CYC_PER_MS (`WHP_CLK_HZ / 1000)
// half period of the serial clock in core cycles; two cycles are needed
// because the returning data line passes a two-stage synchroniser
`define WHP_SPI_HALF_MIN 8'h02
`define WHP_SPI_HALF_RST 8'h02
`define WHP_BAUD_DIV_RST 16'(`WHP_CLK_HZ / `WHP_BAUD_DEF)
`define WHP_BAUD_DIV_MIN 16'((`WHP_CLK_HZ + `WHP_BAUD_MAX - 1) / `WHP_BAUD_MAX)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WHP_OFF_CTRL 8'h00
`define WHP_OFF_STATUS 8'h04
`define WHP_OFF_SPI_DATA 8'h08
`define WHP_OFF_UART_DATA 8'h0c
`define WHP_OFF_UART_WORD 8'h10
`define WHP_OFF_SPI_HALF 8'h14
`define WHP_OFF_BAUD 8'h18
`define WHP_OFF_EVT_STAT 8'h1c
`define WHP_OFF_EVT_CLR 8'h20
`define WHP_OFF_EVT_EN 8'h24

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define WHP_CTRL_SLEEP 0
`define WHP_CTRL_HOLD 1
`define WHP_CTRL_RECAL 2
`define WHP_CTRL_RST 3'h0
`define WHP_EV_SPI 0
`define WHP_EV_RX 1
`define WHP_EV_ATTN 2
`define WHP_EV_AWAKE 3
`define WHP_EV_TXDONE 4
`define WHP_EV_RST 5'h00

`endif

// >>> rtl/whp_pkg.sv
// types shared by the host port controller
`default_nettype none
package whp_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} whp_req_s;
	typedef enum logic [3:0] {
		PWR_BOOT = 4'h1, PWR_UP = 4'h2, PWR_HIB = 4'h4, PWR_WAKE = 4'h8
	} whp_pwr_e;
	typedef enum logic [3:0] {
		SPI_IDLE = 4'h1, SPI_LEAD = 4'h2, SPI_SHIFT = 4'h4, SPI_TRAIL = 4'h8
	} whp_spi_e;
	typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_BUSY = 2'h2} whp_tx_e;
	typedef enum logic [1:0] {RX_IDLE = 2'h1, RX_BITS = 2'h2} whp_rx_e;
endpackage
`default_nettype wire

// >>> rtl/whp_uart.sv
// 8n1 uart with rts/cts flow control for the host port controller
`default_nettype none
module whp_uart (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] baud_div,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_take,
	output logic uart_tx,
	input wire logic uart_rx,
	input wire logic cts_n,
	output logic rts_n
);
	logic rx_s1, rx_s2, cts_s1, cts_s2;
	whp_pkg::whp_tx_e tx_st, next_tx_st;
	whp_pkg::whp_rx_e rx_st, next_rx_st;
	logic [15:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
	logic [3:0] tx_bit, next_tx_bit, rx_bit, next_rx_bit;
	logic [9:0] tx_sh, next_tx_sh;
	logic [7:0] rx_sh, next_rx_sh, next_rx_data;
	logic next_rx_valid;

	// device may send only while we hold rts low; we send only on cts low
	assign tx_ready = (tx_st == whp_pkg::TX_IDLE) && !cts_s2;
	assign rts_n = rx_valid;
	assign uart_tx = tx_sh[0];

	always_comb begin
		next_tx_st = tx_st;
		next_tx_cnt = tx_cnt;
		next_tx_bit = tx_bit;
		next_tx_sh = tx_sh;
		case (tx_st)
		whp_pkg::TX_IDLE: begin
			if (tx_valid && tx_ready) begin
				// stop, data lsb first, start: no parity bit
				next_tx_sh = {1'b1, tx_data, 1'b0};
				next_tx_cnt = 16'h0000;
				next_tx_bit = 4'h0;
				next_tx_st = whp_pkg::TX_BUSY;
			end
		end
		default: begin
			if (tx_cnt >= baud_div - 16'h0001) begin
				next_tx_cnt = 16'h0000;
				next_tx_sh = {1'b1, tx_sh[9:1]};
				next_tx_bit = tx_bit + 4'h1;
				if (tx_bit == 4'h9) begin
					next_tx_st = whp_pkg::TX_IDLE;
				end
			end else begin
				next_tx_cnt = tx_cnt + 16'h0001;
			end
		end
		endcase
	end

	always_comb begin
		next_rx_st = rx_st;
		next_rx_cnt = rx_cnt;
		next_rx_bit = rx_bit;
		next_rx_sh = rx_sh;
		next_rx_data = rx_data;
		next_rx_valid = rx_valid && !rx_take;
		case (rx_st)
		whp_pkg::RX_IDLE: begin
			if (!rx_s2) begin
				next_rx_cnt = {1'b0, baud_div[15:1]};
				next_rx_bit = 4'h0;
				next_rx_st = whp_pkg::RX_BITS;
			end
		end
		default: begin
			if (rx_cnt == 16'h0000) begin
				next_rx_cnt = baud_div - 16'h0001;
				next_rx_bit = rx_bit + 4'h1;
				if (rx_bit == 4'h0 && rx_s2) begin
					next_rx_st = whp_pkg::RX_IDLE;
				end else if (rx_bit == 4'h9) begin
					next_rx_st = whp_pkg::RX_IDLE;
					if (rx_s2) begin
						next_rx_data = rx_sh;
						next_rx_valid = 1'b1;
					end
				end else if (rx_bit != 4'h0) begin
					next_rx_sh = {rx_s2, rx_sh[7:1]};
				end
			end else begin
				next_rx_cnt = rx_cnt - 16'h0001;
			end
		end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			cts_s1 <= 1'b1;
			cts_s2 <= 1'b1;
			tx_st <= whp_pkg::TX_IDLE;
			tx_cnt <= 16'h0000;
			tx_bit <= 4'h0;
			tx_sh <= 10'h3ff;
			rx_st <= whp_pkg::RX_IDLE;
			rx_cnt <= 16'h0000;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_s1 <= uart_rx;
			rx_s2 <= rx_s1;
			cts_s1 <= cts_n;
			cts_s2 <= cts_s1;
			tx_st <= next_tx_st;
			tx_cnt <= next_tx_cnt;
			tx_bit <= next_tx_bit;
			tx_sh <= next_tx_sh;
			rx_st <= next_rx_st;
			rx_cnt <= next_rx_cnt;
			rx_bit <= next_rx_bit;
			rx_sh <= next_rx_sh;
			rx_data <= next_rx_data;
			rx_valid <= next_rx_valid;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_start_bit;
		!uart_tx [*7];
	endsequence
	AST_START_BIT: assert property (
		tx_st == whp_pkg::TX_IDLE && next_tx_st == whp_pkg::TX_BUSY
		|=> s_start_bit) else $error("start bit too short");
	AST_CTS_HOLD: assert property (
		tx_st == whp_pkg::TX_IDLE && cts_s2 |=> tx_st == whp_pkg::TX_IDLE)
		else $error("frame started while cts high");
endmodule
`default_nettype wire

// >>> rtl/whp_host.sv
// host-side controller for the network module: spi, uart and sleep pin
//
// The strobed register port and the address map were decided locally.
`include "whp_map.svh"
`default_nettype none
// ----------------------------------------------------------------
// What this block does
// - the serial clock never runs faster than the supported maximum.
// - this controller makes the serial clock; the module only receives it.
// - a low select frames each transfer and high leaves the module idle.
// - data goes out on the mosi line and comes back on miso, full duplex.
// - every low pulse on the sleep pin lasts at least the minimum width.
// - after releasing the sleep pin we wait the wake time before talking.
// - an optional extra wait covers recalibration after a heat change.
// - after reset we wait the hardware wake plus initialisation time.
// - the uart starts at the default rate; software may raise it.
// - the uart is 8 data bits, no parity, one stop, lsb first, rts/cts.
// - the attention line is active high and caught on its rising edge.
// - multi-byte uart words are sent lowest byte first.
// ----------------------------------------------------------------
module whp_host #(
	parameter int unsigned HIB_MIN_CYC = `WHP_HIB_MIN_MS * `WHP_CYC_PER_MS,
	parameter int unsigned WAKE_CYC = `WHP_WAKE_MS * `WHP_CYC_PER_MS,
	parameter int unsigned RECAL_CYC = `WHP_RECAL_MS * `WHP_CYC_PER_MS,
	parameter int unsigned BOOT_CYC =
		(`WHP_HW_WAKE_MS + `WHP_INIT_MS) * `WHP_CYC_PER_MS,
	parameter int SPI_BITS = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire whp_pkg::whp_req_s bus_req,
	output logic [31:0] rd_data,
	output logic irq,
	output logic spi_sclk,
	output logic host_select_n,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic device_attention_irq,
	output logic sleep_request_n,
	output logic uart_tx,
	input wire logic uart_rx,
	input wire logic uart_cts_n,
	output logic uart_rts_n
);
	localparam int BW = $clog2(SPI_BITS);

	function automatic logic reached(input logic [31:0] cnt,
		input logic [31:0] lim);
		reached = cnt >= lim - 32'h1;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [2:0] ctrl, next_ctrl;
	logic [4:0] en, next_en, evt, next_evt, clr, ev_set;
	logic [7:0] spi_half, next_half;
	logic [15:0] baud_div, next_baud;
	logic [31:0] next_rd;
	logic att1, att2, att3, mi1, mi2, rv_q;
	logic spi_go, tx_byte, tx_word, rx_take, spi_done, awake_evt, txw_evt;
	whp_pkg::whp_pwr_e pwr_st, next_pwr;
	logic [31:0] pwr_cnt, next_pcnt, wake_lim;
	logic next_sleep_n;
	whp_pkg::whp_spi_e spi_st, next_spi;
	logic [7:0] hcnt, next_hcnt;
	logic [BW-1:0] bcnt, next_bcnt;
	logic [SPI_BITS-1:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
	logic [SPI_BITS-1:0] rx_word, next_rx_word;
	logic next_sclk, next_mosi, next_cs_n;
	logic [31:0] wsh, next_wsh;
	logic [2:0] wleft, next_wleft;
	logic u_tx_ready, u_rx_valid;
	logic [7:0] u_rx_data;
	logic awake, spi_busy;

	assign awake = pwr_st == whp_pkg::PWR_UP;
	assign spi_busy = spi_st != whp_pkg::SPI_IDLE;
	assign irq = |(evt & en);

	// ----------------------------------------------------------------
	// register port and events
	// ----------------------------------------------------------------
	always_comb begin
		ev_set = `WHP_EV_RST;
		ev_set[`WHP_EV_SPI] = spi_done;
		ev_set[`WHP_EV_RX] = u_rx_valid && !rv_q;
		ev_set[`WHP_EV_ATTN] = att2 && !att3;
		ev_set[`WHP_EV_AWAKE] = awake_evt;
		ev_set[`WHP_EV_TXDONE] = txw_evt;
	end

	always_comb begin
		next_ctrl = ctrl;
		next_en = en;
		next_half = spi_half;
		next_baud = baud_div;
		clr = `WHP_EV_RST;
		spi_go = 1'b0;
		tx_byte = 1'b0;
		tx_word = 1'b0;
		rx_take = 1'b0;
		next_rd = 32'h0;
		if (bus_req.wr) begin
			if (bus_req.addr == `WHP_OFF_CTRL) begin
				next_ctrl = bus_req.wdata[2:0];
			end else if (bus_req.addr == `WHP_OFF_SPI_DATA) begin
				spi_go = 1'b1;
			end else if (bus_req.addr == `WHP_OFF_UART_DATA) begin
				tx_byte = 1'b1;
			end else if (bus_req.addr == `WHP_OFF_UART_WORD) begin
				tx_word = 1'b1;
			end else if (bus_req.addr == `WHP_OFF_SPI_HALF) begin
				next_half = (bus_req.wdata[7:0] < `WHP_SPI_HALF_MIN) ?
					`WHP_SPI_HALF_MIN : bus_req.wdata[7:0];
			end else if (bus_req.addr == `WHP_OFF_BAUD) begin
				next_baud = (bus_req.wdata[15:0] < `WHP_BAUD_DIV_MIN) ?
					`WHP_BAUD_DIV_MIN : bus_req.wdata[15:0];
			end else if (bus_req.addr == `WHP_OFF_EVT_CLR) begin
				clr = bus_req.wdata[4:0];
			end else if (bus_req.addr == `WHP_OFF_EVT_EN) begin
				next_en = bus_req.wdata[4:0];
			end
		end
		if (bus_req.rd) begin
			if (bus_req.addr == `WHP_OFF_CTRL) begin
				next_rd = {29'h0, ctrl};
			end else if (bus_req.addr == `WHP_OFF_STATUS) begin
				next_rd = {25'h0, sleep_request_n, u_rx_valid, wleft != 3'h0,
					pwr_st == whp_pkg::PWR_HIB, att2, spi_busy, awake};
			end else if (bus_req.addr == `WHP_OFF_SPI_DATA) begin
				next_rd = 32'(rx_word);
			end else if (bus_req.addr == `WHP_OFF_UART_DATA) begin
				next_rd = {24'h0, u_rx_data};
				rx_take = 1'b1;
			end else if (bus_req.addr == `WHP_OFF_SPI_HALF) begin
				next_rd = {24'h0, spi_half};
			end else if (bus_req.addr == `WHP_OFF_BAUD) begin
				next_rd = {16'h0, baud_div};
			end else if (bus_req.addr == `WHP_OFF_EVT_STAT) begin
				next_rd = {27'h0, evt};
			end else if (bus_req.addr == `WHP_OFF_EVT_EN) begin
				next_rd = {27'h0, en};
			end
		end
		// a new event in the clearing cycle survives
		next_evt = (evt & ~clr) | ev_set;
	end

	// ----------------------------------------------------------------
	// sleep pin sequencing
	// ----------------------------------------------------------------
	always_comb begin
		next_pwr = pwr_st;
		next_pcnt = pwr_cnt + 32'h1;
		next_sleep_n = sleep_request_n;
		awake_evt = 1'b0;
		wake_lim = ctrl[`WHP_CTRL_RECAL] ? WAKE_CYC + RECAL_CYC : WAKE_CYC;
		case (pwr_st)
		whp_pkg::PWR_BOOT: begin
			if (reached(pwr_cnt, BOOT_CYC)) begin
				next_pwr = whp_pkg::PWR_UP;
				awake_evt = 1'b1;
			end
		end
		whp_pkg::PWR_UP: begin
			next_pcnt = pwr_cnt;
			if (ctrl[`WHP_CTRL_SLEEP] && !spi_busy) begin
				next_pwr = whp_pkg::PWR_HIB;
				next_pcnt = 32'h0;
				next_sleep_n = 1'b0;
			end
		end
		whp_pkg::PWR_HIB: begin
			// the pin stays low for the full minimum even if sleep is dropped
			if (reached(pwr_cnt, HIB_MIN_CYC)) begin
				next_pcnt = pwr_cnt;
				if (!ctrl[`WHP_CTRL_SLEEP]) begin
					next_pwr = whp_pkg::PWR_WAKE;
					next_pcnt = 32'h0;
					next_sleep_n = 1'b1;
				end
			end
		end
		whp_pkg::PWR_WAKE: begin
			if (ctrl[`WHP_CTRL_SLEEP]) begin
				next_pwr = whp_pkg::PWR_HIB;
				next_pcnt = 32'h0;
				next_sleep_n = 1'b0;
			end else if (reached(pwr_cnt, wake_lim)) begin
				next_pwr = whp_pkg::PWR_UP;
				awake_evt = 1'b1;
			end
		end
		default: begin
			next_pwr = whp_pkg::PWR_BOOT;
			next_pcnt = 32'h0;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// serial peripheral master, mode 0, msb first
	// ----------------------------------------------------------------
	always_comb begin
		next_spi = spi_st;
		next_hcnt = hcnt + 8'h01;
		next_bcnt = bcnt;
		next_tx_sh = tx_sh;
		next_rx_sh = rx_sh;
		next_rx_word = rx_word;
		next_sclk = spi_sclk;
		next_mosi = spi_mosi;
		spi_done = 1'b0;
		case (spi_st)
		whp_pkg::SPI_IDLE: begin
			next_sclk = 1'b0;
			if (spi_go && awake) begin
				next_spi = whp_pkg::SPI_LEAD;
				next_hcnt = 8'h00;
				next_tx_sh = bus_req.wdata[SPI_BITS-1:0];
				next_mosi = bus_req.wdata[SPI_BITS-1];
			end
		end
		whp_pkg::SPI_LEAD: begin
			// select leads the first clock edge by a half period
			if (reached({24'h0, hcnt}, {24'h0, spi_half})) begin
				next_spi = whp_pkg::SPI_SHIFT;
				next_hcnt = 8'h00;
				next_bcnt = '0;
				next_sclk = 1'b1;
			end
		end
		whp_pkg::SPI_SHIFT: begin
			if (reached({24'h0, hcnt}, {24'h0, spi_half})) begin
				next_hcnt = 8'h00;
				next_sclk = !spi_sclk;
				if (spi_sclk) begin
					next_rx_sh = {rx_sh[SPI_BITS-2:0], mi2};
					if (bcnt == BW'(SPI_BITS - 1)) begin
						next_spi = whp_pkg::SPI_TRAIL;
					end else begin
						next_bcnt = bcnt + BW'(1);
						next_tx_sh = {tx_sh[SPI_BITS-2:0], 1'b0};
						next_mosi = tx_sh[SPI_BITS-2];
					end
				end
			end
		end
		whp_pkg::SPI_TRAIL: begin
			if (reached({24'h0, hcnt}, {24'h0, spi_half})) begin
				next_spi = whp_pkg::SPI_IDLE;
				next_rx_word = rx_sh;
				spi_done = 1'b1;
			end
		end
		default: begin
			next_spi = whp_pkg::SPI_IDLE;
		end
		endcase
		next_cs_n = !((ctrl[`WHP_CTRL_HOLD] && awake) ||
			next_spi != whp_pkg::SPI_IDLE);
	end

	// ----------------------------------------------------------------
	// uart feeder: words leave lowest byte first
	// ----------------------------------------------------------------
	always_comb begin
		next_wsh = wsh;
		next_wleft = wleft;
		txw_evt = 1'b0;
		if (wleft == 3'h0) begin
			if (tx_word && awake) begin
				next_wsh = bus_req.wdata;
				next_wleft = 3'h4;
			end else if (tx_byte && awake) begin
				next_wsh = {24'h0, bus_req.wdata[7:0]};
				next_wleft = 3'h1;
			end
		end else if (u_tx_ready) begin
			next_wsh = {8'h0, wsh[31:8]};
			next_wleft = wleft - 3'h1;
			txw_evt = wleft == 3'h1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl <= `WHP_CTRL_RST;
			en <= `WHP_EV_RST;
			evt <= `WHP_EV_RST;
			spi_half <= `WHP_SPI_HALF_RST;
			baud_div <= `WHP_BAUD_DIV_RST;
			rd_data <= 32'h0;
			att1 <= 1'b0;
			att2 <= 1'b0;
			att3 <= 1'b0;
			mi1 <= 1'b0;
			mi2 <= 1'b0;
			rv_q <= 1'b0;
			pwr_st <= whp_pkg::PWR_BOOT;
			pwr_cnt <= 32'h0;
			sleep_request_n <= 1'b1;
			spi_st <= whp_pkg::SPI_IDLE;
			hcnt <= 8'h00;
			bcnt <= '0;
			tx_sh <= '0;
			rx_sh <= '0;
			rx_word <= '0;
			spi_sclk <= 1'b0;
			spi_mosi <= 1'b0;
			host_select_n <= 1'b1;
			wsh <= 32'h0;
			wleft <= 3'h0;
		end else begin
			ctrl <= next_ctrl;
			en <= next_en;
			evt <= next_evt;
			spi_half <= next_half;
			baud_div <= next_baud;
			rd_data <= next_rd;
			att1 <= device_attention_irq;
			att2 <= att1;
			att3 <= att2;
			mi1 <= spi_miso;
			mi2 <= mi1;
			rv_q <= u_rx_valid;
			pwr_st <= next_pwr;
			pwr_cnt <= next_pcnt;
			sleep_request_n <= next_sleep_n;
			spi_st <= next_spi;
			hcnt <= next_hcnt;
			bcnt <= next_bcnt;
			tx_sh <= next_tx_sh;
			rx_sh <= next_rx_sh;
			rx_word <= next_rx_word;
			spi_sclk <= next_sclk;
			spi_mosi <= next_mosi;
			host_select_n <= next_cs_n;
			wsh <= next_wsh;
			wleft <= next_wleft;
		end
	end

	whp_uart whp_uart_inst (
		.core_clk(core_clk),
		.rst(rst),
		.baud_div(baud_div),
		.tx_data(wsh[7:0]),
		.tx_valid(wleft != 3'h0),
		.tx_ready(u_tx_ready),
		.rx_data(u_rx_data),
		.rx_valid(u_rx_valid),
		.rx_take(rx_take),
		.uart_tx(uart_tx),
		.uart_rx(uart_rx),
		.cts_n(uart_cts_n),
		.rts_n(uart_rts_n)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [31:0] low_cnt, hi_cnt;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			low_cnt <= 32'h0;
			hi_cnt <= 32'h0;
		end else begin
			low_cnt <= sleep_request_n ? 32'h0 : low_cnt + 32'h1;
			hi_cnt <= !sleep_request_n ? 32'h0 :
				(&hi_cnt) ? hi_cnt : hi_cnt + 32'h1;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_SCLK_RATE: assert property ($rose(spi_sclk) |-> spi_sclk [*2])
		else $error("serial clock high phase too short");
	AST_SEL_FRAMES: assert property (spi_sclk |-> !host_select_n)
		else $error("serial clock toggles without select");
	AST_MOSI_STABLE: assert property (
		spi_sclk && !$rose(spi_sclk) |-> $stable(spi_mosi))
		else $error("mosi changed while clock high");
	AST_HIB_MIN: assert property (
		$rose(sleep_request_n) |-> low_cnt >= HIB_MIN_CYC)
		else $error("sleep pulse shorter than minimum");
	AST_WAKE_WAIT: assert property (
		awake && $past(pwr_st) == whp_pkg::PWR_WAKE |-> hi_cnt >= WAKE_CYC)
		else $error("wake wait too short");
	AST_BOOT_WAIT: assert property (
		awake && $past(pwr_st) == whp_pkg::PWR_BOOT |-> hi_cnt >= BOOT_CYC)
		else $error("boot wait too short");
	AST_NO_XFER_ASLEEP: assert property (spi_busy |-> awake)
		else $error("transfer while module not awake");
	AST_ATTN_EVT: assert property (
		att2 && !att3 |=> evt[`WHP_EV_ATTN])
		else $error("attention rise not recorded");
	AST_SET_WINS: assert property (
		|ev_set |=> (evt & $past(ev_set)) == $past(ev_set))
		else $error("event lost against clear");
endmodule
`default_nettype wire

// >>> tb/whp_dev_model.sv
// behavioural network module seen from the host port
`default_nettype none
module whp_dev_model #(
	parameter int BIT = 7
) (
	input wire logic core_clk,
	input wire logic spi_sclk,
	input wire logic host_select_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic device_attention_irq,
	input wire logic sleep_request_n,
	input wire logic uart_tx,
	output logic uart_rx,
	output logic uart_cts_n,
	input wire logic uart_rts_n,
	input wire logic attn,
	input wire logic [7:0] reply
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	logic [7:0] tx;
	logic [7:0] u;
	int n = 0;
	int err = 0;
	logic [7:0] spi_q[$];
	logic [7:0] ua_q[$];
	initial begin
		spi_miso = 1'b0;
		uart_rx = 1'b1;
	end
	// ----------------------------------------------------------------
	// attention, flow control and hibernate
	// ----------------------------------------------------------------
	assign device_attention_irq = attn;
	assign uart_cts_n = 1'b0;
	// a select while hibernating is a host fault and is counted as an error
	always @(negedge host_select_n) begin
		if (!sleep_request_n)
			err++;
		n = 0;
		tx = reply;
		// non-blocking so the first bit lands after the idle toggle of this edge
		spi_miso <= reply[7];
	end
	// ----------------------------------------------------------------
	// serial link, clocked only by the host
	// ----------------------------------------------------------------
	always @(posedge spi_sclk) if (!host_select_n) begin
		sh = {sh[6:0], spi_mosi};
		n++;
		if (n == 8)
			spi_q.push_back(sh);
	end
	always @(negedge spi_sclk) if (!host_select_n && n < 8) begin
		spi_miso = tx[7-n];
	end
	// released line shows a changing pattern, not the last bit
	always @(posedge core_clk) if (host_select_n) begin
		spi_miso <= ~spi_miso;
	end
	// ----------------------------------------------------------------
	// uart, 8n1 lsb first
	// ----------------------------------------------------------------
	always begin
		@(negedge uart_tx);
		repeat (BIT / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge core_clk);
			u[i] = uart_tx;
		end
		repeat (BIT) @(posedge core_clk);
		if (uart_tx === 1'b1)
			ua_q.push_back(u);
		else
			err++;
	end
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			uart_rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT) @(posedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/whp_host_tb.sv
// self-checking bench for the host port controller
`include "whp_map.svh"
`default_nettype none
module whp_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HIB = 20;
	localparam int WAKE = 30;
	localparam int RECAL = 40;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	whp_pkg::whp_req_s bus_req = '0;
	logic [31:0] rd_data;
	logic irq, spi_sclk, host_select_n, spi_mosi, spi_miso;
	logic device_attention_irq, sleep_request_n, uart_tx, uart_rx;
	logic uart_cts_n, uart_rts_n;
	logic attn = 1'b0;
	logic [7:0] reply = 8'h00;
	logic [31:0] seed = 32'h36ba0383;
	logic [31:0] d;
	logic [7:0] exp_q[$];
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int n = 0;
	int low_len = 0;
	always #25 core_clk = ~core_clk;
	whp_host #(.HIB_MIN_CYC(HIB), .WAKE_CYC(WAKE), .RECAL_CYC(RECAL),
		.BOOT_CYC(50)) whp_host_inst (.core_clk(core_clk), .rst(rst),
		.bus_req(bus_req), .rd_data(rd_data), .irq(irq),
		.spi_sclk(spi_sclk), .host_select_n(host_select_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.device_attention_irq(device_attention_irq),
		.sleep_request_n(sleep_request_n), .uart_tx(uart_tx),
		.uart_rx(uart_rx), .uart_cts_n(uart_cts_n), .uart_rts_n(uart_rts_n));
	whp_dev_model #(.BIT(7)) whp_dev_model_inst (.core_clk(core_clk),
		.spi_sclk(spi_sclk), .host_select_n(host_select_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.device_attention_irq(device_attention_irq),
		.sleep_request_n(sleep_request_n), .uart_tx(uart_tx),
		.uart_rx(uart_rx), .uart_cts_n(uart_cts_n), .uart_rts_n(uart_rts_n),
		.attn(attn), .reply(reply));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		bus_req <= {1'b1, 1'b0, a, v};
		@(posedge core_clk);
		bus_req <= '0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		bus_req <= {1'b0, 1'b1, a, 32'h0};
		@(posedge core_clk);
		bus_req <= '0;
		#1;
		d = rd_data;
		chk(d, exp);
	endtask
	// polls a register bit until set, counting the cycles waited
	task automatic wait_bit(input logic [7:0] a, input int b);
		n = 0;
		do begin
			@(posedge core_clk);
			bus_req <= {1'b0, 1'b1, a, 32'h0};
			@(posedge core_clk);
			bus_req <= '0;
			#1;
			d = rd_data;
			n += 2;
		end while (d[b] !== 1'b1 && n < 4000);
		chk(d[b], 1'b1);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (!sleep_request_n)
			low_len <= low_len + 1;
		if (cyc == 40000) begin
			fail_count++;
			$display("BAD %0t timeout", $time);
			tally_and_finish;
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rchk(`WHP_OFF_STATUS, 32'h40);
		rchk(`WHP_OFF_BAUD, 32'had);
		rchk(8'h3c, 32'h0);
		wr(`WHP_OFF_SPI_DATA, 32'h5a);
		wait_bit(`WHP_OFF_STATUS, 0);
		chk(whp_dev_model_inst.spi_q.size(), 0);
		rchk(`WHP_OFF_EVT_STAT, 32'h8);
		wr(`WHP_OFF_BAUD, 32'h3);
		rchk(`WHP_OFF_BAUD, 32'h7);
		wr(`WHP_OFF_SPI_HALF, 32'h0);
		rchk(`WHP_OFF_SPI_HALF, 32'h2);
		wr(`WHP_OFF_EVT_CLR, 32'h1f);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			reply <= seed[15:8];
			wr(`WHP_OFF_SPI_DATA, {24'h0, seed[7:0]});
			wait_bit(`WHP_OFF_EVT_STAT, 0);
			wr(`WHP_OFF_EVT_CLR, 32'h1);
			chk(whp_dev_model_inst.spi_q.pop_front(), seed[7:0]);
			rchk(`WHP_OFF_SPI_DATA, {24'h0, seed[15:8]});
		end
		// hold keeps select low between bytes, release lets it rise
		wr(`WHP_OFF_CTRL, 32'h2);
		repeat (2) @(posedge core_clk);
		chk(host_select_n, 1'b0);
		wr(`WHP_OFF_CTRL, 32'h0);
		repeat (2) @(posedge core_clk);
		chk(host_select_n, 1'b1);
		seed = lfsr(seed);
		wr(`WHP_OFF_UART_WORD, seed);
		for (int i = 0; i < 4; i++)
			exp_q.push_back(seed[8*i +: 8]);
		wr(`WHP_OFF_UART_DATA, 32'ha5);
		wait_bit(`WHP_OFF_EVT_STAT, 4);
		repeat (80) @(posedge core_clk);
		chk(whp_dev_model_inst.ua_q.size(), 4);
		while (exp_q.size() > 0)
			chk(whp_dev_model_inst.ua_q.pop_front(), exp_q.pop_front());
		seed = lfsr(seed);
		whp_dev_model_inst.send(seed[7:0]);
		repeat (4) @(posedge core_clk);
		chk(uart_rts_n, 1'b1);
		rchk(`WHP_OFF_UART_DATA, {24'h0, seed[7:0]});
		repeat (2) @(posedge core_clk);
		chk(uart_rts_n, 1'b0);
		wr(`WHP_OFF_EVT_CLR, 32'h1f);
		wr(`WHP_OFF_EVT_EN, 32'h4);
		attn <= 1'b1;
		repeat (6) @(posedge core_clk);
		attn <= 1'b0;
		#1;
		chk(irq, 1'b1);
		wr(`WHP_OFF_EVT_CLR, 32'h4);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		wr(`WHP_OFF_EVT_EN, 32'h0);
		attn <= 1'b1;
		repeat (6) @(posedge core_clk);
		attn <= 1'b0;
		rchk(`WHP_OFF_EVT_STAT, 32'h4);
		chk(irq, 1'b0);
		for (int r = 0; r < 2; r++) begin
			low_len = 0;
			wr(`WHP_OFF_CTRL, {29'h0, r[0], 2'b01});
			wait_bit(`WHP_OFF_STATUS, 3);
			chk(sleep_request_n, 1'b0);
			wr(`WHP_OFF_SPI_DATA, 32'h33);
			wr(`WHP_OFF_CTRL, {29'h0, r[0], 2'b00});
			// measure the wake wait from the release of the pin
			wait (sleep_request_n === 1'b1);
			wait_bit(`WHP_OFF_STATUS, 0);
			chk(low_len >= HIB, 1'b1);
			chk(n >= WAKE + r * RECAL, 1'b1);
			chk(n <= WAKE + r * RECAL + 2, 1'b1);
			chk(whp_dev_model_inst.err, 0);
			chk(whp_dev_model_inst.spi_q.size(), 0);
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
